// ### hdl/hifr_map.vh
// register map, field positions and reset values of the irq mask / frame block
`ifndef HIFR_MAP_VH
`define HIFR_MAP_VH
// command codes (low seven bits select, bit 7 marks a write)
`define HIFR_CMD_IE_RD 8'h04
`define HIFR_CMD_IE_WR 8'h84
`define HIFR_CMD_ID_RD 8'h05
`define HIFR_CMD_ID_WR 8'h85
`define HIFR_CMD_FI_RD 8'h0d
`define HIFR_CMD_FI_WR 8'h8d
`define HIFR_CMD_FR_RD 8'h0e
`define HIFR_CMD_CS_WR 8'h88
// interrupt mask layout
`define HIFR_MIE_BIT 31
`define HIFR_EV_MASK 7'h7d
`define HIFR_EV_W 7
`define HIFR_CS_HCR_BIT 0
// frame interval layout
`define HIFR_FI_MSB 13
`define HIFR_FI_W 14
`define HIFR_LP_LSB 16
`define HIFR_LP_MSB 30
`define HIFR_LP_W 15
`define HIFR_FIT_BIT 31
`define HIFR_FI_NOMINAL 14'h2edf
`define HIFR_BT_DIV 4'h7
`define HIFR_ZERO32 32'h00000000
`define HIFR_MIE_RST 1'b1
`define HIFR_EV_PAD_W 24
`define HIFR_FI_PAD_W 2
`define HIFR_FR_PAD_W 17
`define HIFR_DIV_ZERO 4'h0
`define HIFR_DIV_STEP 4'h1
`endif

// ### hdl/hifr_frame_timer.v
// frame remaining down-counter with toggle capture and frame start strobe
`timescale 1ns/1ps
`include "hifr_map.vh"
module hifr_frame_timer (
    input wire clk,
    input wire rst_n,
    input wire bit_tick,
    input wire run,
    input wire [`HIFR_FI_W-1:0] interval,
    input wire interval_toggle,
    output reg [`HIFR_FI_W-1:0] bits_left_q,
    output reg bits_left_toggle_q,
    output reg frame_start_q
);
    // -------------------------------------------------------------
    // countdown
    // -------------------------------------------------------------
    // reload on the bit time after zero, so a frame spans interval+1 bits
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            bits_left_q <= {`HIFR_FI_W{1'b0}};
            bits_left_toggle_q <= 1'b0;
            frame_start_q <= 1'b0;
        end else begin
            frame_start_q <= 1'b0;
            if (!run) begin
                bits_left_q <= {`HIFR_FI_W{1'b0}};
            end else if (bit_tick) begin
                if (bits_left_q == {`HIFR_FI_W{1'b0}}) begin
                    bits_left_q <= interval;
                    bits_left_toggle_q <= interval_toggle;
                    frame_start_q <= 1'b1;
                end else begin
                    bits_left_q <= bits_left_q - 1'b1;
                end
            end
        end
    end
endmodule // hifr_frame_timer

// ### hdl/hifr_regs.v
// interrupt mask and frame interval register bank of the host controller
`timescale 1ns/1ps
`include "hifr_map.vh"
// Overview of operation
// - writing one to a clear-register bit clears that enable bit
// - writing zero to a clear-register bit leaves that enable bit alone
// - reading the clear register returns the live enable register
// - clear register is read with code 05h and written with 85h
// - one at bit 31 clears master irq enable; zero does nothing
// - master field shows set after hardware or software reset
// - per-event clear bits 6,5,4,3,2,0; bits 30..7 and 1 reserved
// - frame interval register read with code 0Dh, written with 8Dh
// - bits 13..0 hold bits between frames; reset value 11999
// - controller reset command returns interval field to nominal
// - largest packet field loads the packet counter each frame start
// - packet counter gives largest transfer in bits without overrun
// - interrupt only when event, its enable and master enable all set
// - remaining counter drops each bit time, reloads after zero
// - at zero the interval toggle is copied to the remaining toggle

// command port: one strobe cycle, read data in the next cycle only
// read codes 04/05/0d/0e, write codes 84/85/88/8d; others are ignored
// code 88 with bit 0 set acts as the controller reset command
// the bit-time tick is a plain divide of clk, so frames run slightly
// short against a true 12 MHz; fine for register behaviour, not for
// timing-accurate bus traffic
//
// read layouts:
//   04/05  {master, 24 x 0, lanes 6..0 with lane 1 always 0}
//   0d     {toggle, budget 14..0, 2 x 0, interval 13..0}
//   0e     {remaining toggle, 17 x 0, remaining 13..0}
// reset state: interval nominal, budget and toggle zero, lanes zero,
// master enable set; the reset command restores the same except that
// budget and toggle keep their values
module hifr_regs (
    input wire clk,
    input wire nrst,
    input wire [7:0] cmd_addr,
    input wire [31:0] cmd_wdata,
    input wire cmd_wr,
    input wire cmd_rd,
    input wire run,
    input wire [`HIFR_EV_W-1:0] event_flags,
    input wire packet_bits_used,
    output reg [31:0] cmd_rdata_q,
    output reg irq_q,
    output reg controller_reset_q,
    output reg frame_start_q,
    output reg [`HIFR_LP_W-1:0] packet_budget_q
);
    // -------------------------------------------------------------
    // reset synchroniser
    // -------------------------------------------------------------
    // assert at once, release after two clean edges so every flop
    // leaves reset in the same cycle
    reg rst_meta_q;
    reg rst_n_q;
    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            rst_meta_q <= 1'b0;
            rst_n_q <= 1'b0;
        end else begin
            rst_meta_q <= 1'b1;
            rst_n_q <= rst_meta_q;
        end
    end

    // -------------------------------------------------------------
    // bit-time tick (12 MHz from 100 MHz, approximate by /8 divider)
    // -------------------------------------------------------------
    reg [3:0] div_q;
    reg bit_tick_q;
    // coarse rate: a true 12 MHz needs a fractional divider
    always @(posedge clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            div_q <= `HIFR_DIV_ZERO;
            bit_tick_q <= 1'b0;
        end else begin
            bit_tick_q <= (div_q == `HIFR_BT_DIV);
            // wrap rather than free-run so the tick period is exact
            if (div_q == `HIFR_BT_DIV) begin
                div_q <= `HIFR_DIV_ZERO;
            end else begin
                div_q <= div_q + `HIFR_DIV_STEP;
            end
        end
    end

    // -------------------------------------------------------------
    // command decode
    // -------------------------------------------------------------
    // codes are matched whole: bit 7 alone does not make a write, so a
    // strobe with an unknown code changes nothing
    wire wr_ie = cmd_wr && (cmd_addr == `HIFR_CMD_IE_WR);
    wire wr_id = cmd_wr && (cmd_addr == `HIFR_CMD_ID_WR);
    wire wr_fi = cmd_wr && (cmd_addr == `HIFR_CMD_FI_WR);
    wire wr_cs = cmd_wr && (cmd_addr == `HIFR_CMD_CS_WR);
    wire sw_reset = wr_cs && cmd_wdata[`HIFR_CS_HCR_BIT];

    // -------------------------------------------------------------
    // interrupt enable bits
    // -------------------------------------------------------------
    localparam [`HIFR_EV_W-1:0] ev_live = `HIFR_EV_MASK;
    reg mie_q;
    wire [`HIFR_EV_W-1:0] ev_en;
    wire [`HIFR_EV_W-1:0] ev_wdata = cmd_wdata[`HIFR_EV_W-1:0];
    wire mie_bit = cmd_wdata[`HIFR_MIE_BIT];
    // master enable leaves either reset set, so the master field of the
    // clear register reads as one until software clears it
    always @(posedge clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            mie_q <= `HIFR_MIE_RST;
        end else if (sw_reset) begin
            mie_q <= `HIFR_MIE_RST;
        end else if (wr_ie && mie_bit) begin
            mie_q <= 1'b1;
        end else if (wr_id && mie_bit) begin
            mie_q <= 1'b0;
        end
    end

    // one flop per live event lane; reserved lanes have no flop at all,
    // so no write can ever make them read back as one
    genvar g;
    generate
        for (g = 0; g < `HIFR_EV_W; g = g + 1) begin : g_ev
            if (ev_live[g]) begin : g_live
                reg lane_q;
                // a zero on the clear code falls through: lane kept
                always @(posedge clk or negedge rst_n_q) begin
                    if (!rst_n_q) begin
                        lane_q <= 1'b0;
                    end else if (sw_reset) begin
                        lane_q <= 1'b0;
                    end else if (wr_ie && ev_wdata[g]) begin
                        lane_q <= 1'b1;
                    end else if (wr_id && ev_wdata[g]) begin
                        lane_q <= 1'b0;
                    end
                end
                assign ev_en[g] = lane_q;
            end else begin : g_rsvd
                assign ev_en[g] = 1'b0;
            end
        end
    endgenerate

    // -------------------------------------------------------------
    // frame interval register
    // -------------------------------------------------------------
    reg [`HIFR_FI_W-1:0] interval_q;
    reg [`HIFR_LP_W-1:0] largest_q;
    reg toggle_q;
    // interval field: nominal after either reset, else the last write
    always @(posedge clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            interval_q <= `HIFR_FI_NOMINAL;
        end else if (sw_reset) begin
            interval_q <= `HIFR_FI_NOMINAL;
        end else if (wr_fi) begin
            // a trim at any frame start takes effect at the next reload
            interval_q <= cmd_wdata[`HIFR_FI_MSB:0];
        end
    end

    // budget field is kept across the reset command; software sizes it
    always @(posedge clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            largest_q <= {`HIFR_LP_W{1'b0}};
        end else if (wr_fi) begin
            largest_q <= cmd_wdata[`HIFR_LP_MSB:`HIFR_LP_LSB];
        end
    end

    // toggle is a marker for software only; hardware never flips it
    always @(posedge clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            toggle_q <= 1'b0;
        end else if (wr_fi) begin
            toggle_q <= cmd_wdata[`HIFR_FIT_BIT];
        end
    end

    // -------------------------------------------------------------
    // frame timer
    // -------------------------------------------------------------
    // the timer parks at zero while run is low, so the first tick after
    // run rises starts a frame at once
    wire [`HIFR_FI_W-1:0] bits_left;
    wire bits_left_toggle;
    wire frame_start;
    hifr_frame_timer u_timer (
        .clk(clk),
        .rst_n(rst_n_q),
        .bit_tick(bit_tick_q),
        .run(run),
        .interval(interval_q),
        .interval_toggle(toggle_q),
        .bits_left_q(bits_left),
        .bits_left_toggle_q(bits_left_toggle),
        .frame_start_q(frame_start)
    );

    // -------------------------------------------------------------
    // largest packet budget counter
    // -------------------------------------------------------------
    // stop at zero: a wrap would hand the scheduler a huge fresh budget
    wire budget_step = packet_bits_used && bit_tick_q &&
                       (packet_budget_q != {`HIFR_LP_W{1'b0}});
    // counts down in bits as the transfer engine consumes bit times
    always @(posedge clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            packet_budget_q <= {`HIFR_LP_W{1'b0}};
        end else if (frame_start) begin
            packet_budget_q <= largest_q;
        end else if (budget_step) begin
            packet_budget_q <= packet_budget_q - 1'b1;
        end
    end

    // -------------------------------------------------------------
    // outputs: interrupt, strobes and read data
    // -------------------------------------------------------------
    wire [31:0] ie_view = {mie_q, {`HIFR_EV_PAD_W{1'b0}}, ev_en};
    // bits 15..14 have no storage, so they always read as zero
    wire [31:0] fi_view = {toggle_q, largest_q, {`HIFR_FI_PAD_W{1'b0}},
                           interval_q};
    wire [31:0] fr_view = {bits_left_toggle, {`HIFR_FR_PAD_W{1'b0}},
                           bits_left};
    wire [`HIFR_EV_W-1:0] ev_pending = event_flags & ev_en;
    reg [31:0] rdata_d;
    // read data stands only in the cycle after the strobe; an unknown
    // code returns zero rather than a stale word
    always @* begin
        rdata_d = `HIFR_ZERO32;
        if (cmd_rd) begin
            case (cmd_addr)
                `HIFR_CMD_IE_RD: rdata_d = ie_view;
                `HIFR_CMD_ID_RD: rdata_d = ie_view;
                `HIFR_CMD_FI_RD: rdata_d = fi_view;
                `HIFR_CMD_FR_RD: rdata_d = fr_view;
                default: rdata_d = `HIFR_ZERO32;
            endcase
        end
    end

    // read data register; back to zero when no read is in flight
    always @(posedge clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            cmd_rdata_q <= `HIFR_ZERO32;
        end else begin
            cmd_rdata_q <= rdata_d;
        end
    end

    // -------------------------------------------------------------
    // interrupt request
    // -------------------------------------------------------------
    // registered so the pin never glitches, at one cycle of latency
    always @(posedge clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            irq_q <= 1'b0;
        end else begin
            irq_q <= mie_q && (|ev_pending);
        end
    end

    // -------------------------------------------------------------
    // strobes
    // -------------------------------------------------------------
    // one-cycle notice that the reset command landed; the register
    // effects take place on the same edge
    always @(posedge clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            controller_reset_q <= 1'b0;
        end else begin
            controller_reset_q <= sw_reset;
        end
    end

    // frame start retimed once more so the pin leaves a local flop
    always @(posedge clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            frame_start_q <= 1'b0;
        end else begin
            frame_start_q <= frame_start;
        end
    end
endmodule // hifr_regs

// ### testbench/hifr_regs_sva.sv
// assertion checker for the irq mask and frame interval bank
`timescale 1ns/1ps
module hifr_regs_sva (
    input wire clk,
    input wire nrst,
    input wire [7:0] cmd_addr,
    input wire [31:0] cmd_wdata,
    input wire cmd_wr,
    input wire cmd_rd,
    input wire [6:0] event_flags,
    input wire [31:0] cmd_rdata_q,
    input wire irq_q,
    input wire controller_reset_q,
    input wire frame_start_q,
    input wire [14:0] packet_budget_q
);
    reg [31:0] en_q;
    reg [31:0] fi_q;
    reg [31:0] exp_q;
    wire sw_rst = cmd_wr && cmd_addr == 8'h88 && cmd_wdata[0];
    wire hit = cmd_addr == 8'h04 || cmd_addr == 8'h05;
    wire known = hit || cmd_addr == 8'h0d || cmd_addr == 8'h0e;
    // shadow of what software wrote; a read sees it one edge on
    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            en_q <= 32'h80000000;
            fi_q <= 32'h2edf;
            exp_q <= 32'h0;
        end else begin
            exp_q <= cmd_addr == 8'h0d ? fi_q : hit ? en_q : 32'h0;
            if (sw_rst) begin
                en_q <= 32'h80000000;
                fi_q <= {fi_q[31:16], 16'h2edf};
            end else if (cmd_wr && cmd_addr == 8'h84)
                en_q <= en_q | (cmd_wdata & 32'h8000007d);
            else if (cmd_wr && cmd_addr == 8'h85)
                en_q <= en_q & ~cmd_wdata;
            else if (cmd_wr && cmd_addr == 8'h8d)
                fi_q <= cmd_wdata & 32'hffff3fff;
        end
    end
    default clocking @(posedge clk);
    endclocking
    default disable iff (!nrst);
    chk_mask_view:
    assert property ($past(cmd_rd) && $past(hit) |-> cmd_rdata_q == exp_q)
        else $error("mask read wrong");
    chk_interval_view:
    assert property ($past(cmd_rd) && $past(cmd_addr) == 8'h0d
        |-> cmd_rdata_q == exp_q) else $error("interval read wrong");
    chk_unmapped_zero:
    assert property ($past(cmd_rd) && !$past(known) |-> cmd_rdata_q == 0)
        else $error("unmapped read not zero");
    chk_idle_zero:
    assert property (!$past(cmd_rd) |-> cmd_rdata_q == 0)
        else $error("read data outside its cycle");
    chk_irq_gate:
    assert property (irq_q == $past(en_q[31] && |(event_flags & en_q[6:0])))
        else $error("irq not gated by enables");
    chk_budget_load:
    assert property ($rose(frame_start_q) |-> packet_budget_q == fi_q[30:16])
        else $error("budget not loaded at frame start");
    chk_frame_gap:
    assert property (frame_start_q |=> !frame_start_q [*8])
        else $error("frame start too soon");
    chk_reset_pulse:
    assert property (sw_rst |=> controller_reset_q ##1 !controller_reset_q)
        else $error("reset pulse wrong");
endmodule // hifr_regs_sva
bind hifr_regs hifr_regs_sva i_chk (.clk(clk), .nrst(nrst),
    .cmd_addr(cmd_addr), .cmd_wdata(cmd_wdata), .cmd_wr(cmd_wr),
    .cmd_rd(cmd_rd), .event_flags(event_flags), .cmd_rdata_q(cmd_rdata_q),
    .irq_q(irq_q), .controller_reset_q(controller_reset_q),
    .frame_start_q(frame_start_q), .packet_budget_q(packet_budget_q));

// ### testbench/hifr_host_model.sv
// host driver model issuing command port cycles
`timescale 1ns/1ps
module hifr_host_model (
    input wire clk,
    input wire [31:0] cmd_rdata_q,
    output reg [7:0] cmd_addr = 8'h00,
    output reg [31:0] cmd_wdata = 32'h0,
    output reg cmd_wr = 1'b0,
    output reg cmd_rd = 1'b0
);
    // write then one idle cycle; released lines show inverted values
    task wr(input [7:0] a, input [31:0] d);
        begin
            cmd_addr <= a;
            cmd_wdata <= d;
            cmd_wr <= 1'b1;
            @(posedge clk);
            cmd_wr <= 1'b0;
            cmd_addr <= ~a;
            cmd_wdata <= ~d;
            @(posedge clk);
        end
    endtask
    // data is taken in the cycle after the strobe only
    task rd(input [7:0] a, output [31:0] d);
        begin
            cmd_addr <= a;
            cmd_rd <= 1'b1;
            @(posedge clk);
            cmd_rd <= 1'b0;
            cmd_addr <= ~a;
            @(posedge clk);
            d = cmd_rdata_q;
        end
    endtask
endmodule // hifr_host_model

// ### testbench/hifr_regs_tb.sv
// self-checking bench for the irq mask and frame interval bank
`timescale 1ns/1ps
module hifr_regs_tb;
    reg clk = 1'b0;
    reg nrst = 1'b0;
    reg run = 1'b0;
    reg [6:0] flags = 7'h00;
    reg used = 1'b0;
    wire [7:0] addr;
    wire [31:0] wdata;
    wire wr;
    wire rd;
    wire [31:0] rdata;
    wire irq;
    wire fstart;
    wire [14:0] budget;
    integer failures = 0;
    integer cmp_count = 0;
    integer m_en = 32'h80000000;
    integer m_fi = 32'h2edf;
    integer i;
    reg [31:0] v;
    reg [31:0] got;
    always #5 clk = ~clk;
    hifr_regs i_dut (.clk(clk), .nrst(nrst), .cmd_addr(addr),
        .cmd_wdata(wdata), .cmd_wr(wr), .cmd_rd(rd), .run(run),
        .event_flags(flags), .packet_bits_used(used),
        .cmd_rdata_q(rdata), .irq_q(irq), .controller_reset_q(),
        .frame_start_q(fstart), .packet_budget_q(budget));
    hifr_host_model i_host (.clk(clk), .cmd_rdata_q(rdata),
        .cmd_addr(addr), .cmd_wdata(wdata), .cmd_wr(wr), .cmd_rd(rd));
    task close_out;
        begin
            $display("checks %0d failures %0d", cmp_count, failures);
            if (failures == 0 && cmp_count > 0)
                $display("*** PASS ***");
            else
                $display("*** FAIL ***");
            $finish;
        end
    endtask
    task cmp(input [47:0] nm, input [31:0] exp, input [31:0] seen);
        begin
            cmp_count = cmp_count + 1;
            if (seen !== exp) begin
                failures = failures + 1;
                $display("mismatch %0s exp %h seen %h", nm, exp, seen);
            end
        end
    endtask
    task rdc(input [7:0] a, input [31:0] exp);
        begin
            i_host.rd(a, got);
            cmp("rdata", exp, got);
        end
    endtask
    // bounded wait for one frame start pulse
    task wait_start;
        integer n;
        begin
            for (n = 0; fstart !== 1'b1 && n < 1000; n = n + 1)
                @(posedge clk);
            if (fstart !== 1'b1) begin
                cmp("fstart", 1, fstart);
                close_out;
            end
            @(posedge clk);
        end
    endtask
    // ----------
    // main sequence
    // ----------
    initial begin
        i = $urandom(32'hbb41);
        repeat (16) @(posedge clk);
        nrst <= 1'b1;
        repeat (3) @(posedge clk);
        rdc(8'h05, 32'h80000000);
        rdc(8'h0d, m_fi);
        rdc(8'h33, 0);
        for (i = 0; i < 8; i = i + 1) begin
            flags <= 7'($urandom);
            v = $urandom;
            i_host.wr(8'h84, v);
            m_en = m_en | (v & 32'h8000007d);
            v = $urandom;
            i_host.wr(8'h85, v);
            m_en = m_en & ~v;
            rdc(8'h05, m_en);
            cmp("irq", m_en[31] && (flags & m_en[6:0]) != 0, irq);
        end
        i_host.wr(8'h84, 32'hffffffff);
        i_host.wr(8'h85, 32'h80000000);
        i_host.wr(8'h85, 32'h0);
        rdc(8'h04, 32'h7d);
        // short interval keeps each frame brief
        v = {1'b1, 15'($urandom) | 15'h1, 2'b11, 14'd20};
        i_host.wr(8'h8d, v);
        m_fi = v & 32'hffff3fff;
        rdc(8'h0d, m_fi);
        run <= 1'b1;
        for (i = 0; i < 2; i = i + 1) begin
            wait_start;
            cmp("budget", v[30:16], budget);
            // one bit tick falls within the next nine cycles
            used <= 1'b1;
            repeat (9) @(posedge clk);
            cmp("budget", v[30:16] - 15'h1, budget);
            used <= 1'b0;
        end
        i_host.rd(8'h0e, got);
        cmp("toggle", v[31], got[31]);
        i_host.rd(8'h0d, got);
        i_host.wr(8'h88, 32'h1);
        m_fi = (m_fi & 32'hffff0000) | 32'h2edf;
        rdc(8'h0d, m_fi);
        rdc(8'h05, 32'h80000000);
        i_host.wr(8'h8d, got ^ 32'h80000000);
        rdc(8'h0d, (got ^ 32'h80000000) & 32'hffff3fff);
        close_out;
    end
endmodule // hifr_regs_tb
